// ### core/push_pull_pkg.sv
// package for the push-pull full-bridge output stage
package push_pull_pkg;
	// number of bridge pins driven in this mode
	localparam int bridge_pins = 4;
	// reset value of the period parity: first period after enable is odd
	localparam logic parity_odd = 1'b1;
	// reset value of a phase output
	localparam logic phase_idle = 1'b0;
	// reset value of the phase output vector
	localparam logic [3:0] phase_idle_vec = 4'h0;

	// timebase events seen by the output stage
	typedef struct packed {
		logic period; // start of a new period
		logic rise; // rising edge event
		logic fall; // falling edge event
	} pwm_events_t;

	// the four internal phase outputs
	typedef struct packed {
		logic three;
		logic two;
		logic one;
		logic zero;
	} phase_outs_t;

	// the four bridge pins
	typedef struct packed {
		logic d;
		logic c;
		logic b;
		logic a;
	} bridge_pins_t;

	// dead-band and steering settings, ignored in this mode
	typedef struct packed {
		logic deadband_en;
		logic [3:0] steer_mask;
	} shaping_cfg_t;

	// stage state
	typedef enum logic [0:0] {
		st_idle,
		st_run
	} stage_state_t;
endpackage

// ### core/bridge_pin_map.sv
// fixed mapping of phase outputs onto the four bridge pins
`timescale 1ns/1ns
`default_nettype none
module bridge_pin_map (
	input wire logic clk,
	input wire logic arst_n,
	input wire push_pull_pkg::phase_outs_t phase,
	output push_pull_pkg::bridge_pins_t pins
);
	import push_pull_pkg::*;

	bridge_pins_t next_pins; // next pin levels
	bridge_pins_t pins_q; // registered pin levels

	// fixed routing: a and c from pair zero/two, b and d from one/three
	always_comb begin
		next_pins.a = phase.zero;
		next_pins.c = phase.two;
		next_pins.b = phase.one;
		next_pins.d = phase.three;
	end

	// register the pins so the pairs switch on the same edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pins_q <= '0;
		end else begin
			pins_q <= next_pins;
		end
	end

	assign pins = pins_q;
endmodule
`default_nettype wire

// ### core/push_pull_full_bridge_pwm.sv
// push-pull output stage with four full-bridge outputs
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - alternate active pair every pwm period
// - odd period rise: set outputs zero, two
// - odd period fall: clear outputs zero, two
// - even period rise: set outputs one, three
// - even period fall: clear outputs one, three
// - dead-band and steering have no effect
// - waveform only on bridge pins a-d
// - a equals c, b equals d
// - pin assignment fixed, six-pin compatible
module push_pull_full_bridge_pwm (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic enable,
	input wire push_pull_pkg::pwm_events_t events,
	input wire push_pull_pkg::shaping_cfg_t shaping,
	output push_pull_pkg::phase_outs_t phase,
	output push_pull_pkg::bridge_pins_t pins,
	output logic odd_period
);
	import push_pull_pkg::*;

	stage_state_t state; // idle or running
	stage_state_t next_state; // next state
	logic parity; // high while in an odd period
	logic next_parity; // next parity
	logic started; // a period event has been seen since enable
	logic next_started; // next started flag
	phase_outs_t outs; // phase output registers
	phase_outs_t next_outs; // next phase outputs
	logic shaping_unused; // shaping settings, deliberately not used

	// dead-band and steering settings are never looked at here
	assign shaping_unused = ^shaping;

	// next-state logic for parity, state and phase outputs
	always_comb begin
		next_state = state;
		next_parity = parity;
		next_started = started;
		next_outs = outs;
		unique case (state)
			st_idle: begin
				// outputs parked inactive, first period will be odd
				next_outs = phase_idle_vec;
				next_parity = parity_odd;
				next_started = 1'b0;
				if (enable) begin
					next_state = st_run;
				end
			end
			st_run: begin
				if (!enable) begin
					// leaving the mode parks all outputs
					next_state = st_idle;
					next_outs = phase_idle_vec;
					next_parity = parity_odd;
					next_started = 1'b0;
				end else begin
					// a period event starts the next period
					if (events.period) begin
						if (started) begin
							next_parity = ~parity;
						end
						next_started = 1'b1;
						// the old pair is finished at period end
						next_outs = phase_idle_vec;
					end
					// rising event: activate the pair of this period
					if (events.rise) begin
						if (next_parity) begin
							next_outs.zero = 1'b1;
							next_outs.two = 1'b1;
						end else begin
							next_outs.one = 1'b1;
							next_outs.three = 1'b1;
						end
					end
					// falling event: release the pair, wins over rise
					if (events.fall) begin
						if (next_parity) begin
							next_outs.zero = phase_idle;
							next_outs.two = phase_idle;
						end else begin
							next_outs.one = phase_idle;
							next_outs.three = phase_idle;
						end
					end
				end
			end
		endcase
	end

	// register the stage state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= st_idle;
			parity <= parity_odd;
			started <= 1'b0;
			outs <= phase_idle_vec;
		end else begin
			state <= next_state;
			parity <= next_parity;
			started <= next_started;
			outs <= next_outs;
		end
	end

	// pins follow the phase outputs through the fixed map
	bridge_pin_map u_map (
		.clk(clk),
		.arst_n(arst_n),
		.phase(outs),
		.pins(pins)
	);

	assign phase = outs;
	assign odd_period = parity;
endmodule
`default_nettype wire

// ### tb/bridge_load.sv
// bridge load model that flags cross-conduction
`timescale 1ns/1ns
`default_nettype none
module bridge_load (
	input wire push_pull_pkg::bridge_pins_t pins,
	output logic short_n
);
	// both legs on together would short the supply
	assign short_n = !(pins.a && pins.b);
endmodule
`default_nettype wire

// ### tb/push_pull_full_bridge_pwm_properties.sv
// checker for the push-pull output stage
`timescale 1ns/1ns
`default_nettype none
module pp_props (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic enable,
	input wire push_pull_pkg::pwm_events_t events,
	input wire push_pull_pkg::shaping_cfg_t shaping,
	input wire push_pull_pkg::phase_outs_t phase,
	input wire push_pull_pkg::bridge_pins_t pins,
	input wire logic odd_period
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// rise alone, or fall without a period event, while enabled
	wire r = events.rise & !events.fall & !events.period & enable;
	wire f = events.fall & !events.period & enable;
	AST_AC: assert property (pins.a == pins.c)
		else $error("a differs from c");
	AST_BD: assert property (pins.b == pins.d)
		else $error("b differs from d");
	AST_MAP: assert property (pins.a == $past(phase.zero) &&
		pins.b == $past(phase.one)) else $error("pin map");
	AST_PAIR: assert property (phase.zero == phase.two &&
		!(phase.zero && phase.one)) else $error("pairs");
	AST_ODD_RISE: assert property (r && odd_period && $past(enable)
		|=> phase.zero && phase.two) else $error("odd rise");
	AST_ODD_FALL: assert property (f && odd_period && $past(enable)
		|=> !phase.zero && !phase.two) else $error("odd fall");
	AST_EVEN_RISE: assert property (r && !odd_period && $past(enable)
		|=> phase.one && phase.three) else $error("even rise");
	AST_EVEN_FALL: assert property (f && !odd_period && $past(enable)
		|=> !phase.one && !phase.three) else $error("even fall");
endmodule
bind push_pull_full_bridge_pwm pp_props chk (.*);
`default_nettype wire

// ### tb/push_pull_full_bridge_pwm_tb.sv
// self-checking bench for the push-pull output stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	miscompares++; $display("[ERR] %0t mismatch", $time); end end
module push_pull_full_bridge_pwm_tb;
	import push_pull_pkg::*;
	logic clk = 0, arst_n = 0, enable = 0;
	pwm_events_t events = '0;
	shaping_cfg_t shaping = '0;
	phase_outs_t phase;
	bridge_pins_t pins;
	logic odd_period, short_n;
	int miscompares = 0, check_count = 0;
	always #20 clk = ~clk;
	push_pull_full_bridge_pwm uut (.clk(clk), .arst_n(arst_n),
		.enable(enable), .events(events), .shaping(shaping),
		.phase(phase), .pins(pins), .odd_period(odd_period));
	bridge_load load (.pins(pins), .short_n(short_n));
	// one-cycle event, then wait until the pins follow
	task automatic pulse(input logic [2:0] ev);
		events = ev;
		@(posedge clk) #1 events = '0;
		@(posedge clk) #1;
	endtask
	task automatic t_odd();
		pulse(3'b100);
		pulse(3'b010);
		`CHK(pins, 4'h5)
		`CHK(phase, 4'h5)
		pulse(3'b001);
		`CHK(pins, 4'h0)
	endtask
	task automatic t_even();
		pulse(3'b100);
		`CHK(odd_period, 1'b0)
		pulse(3'b010);
		`CHK(pins, 4'ha)
		pulse(3'b001);
		`CHK(pins, 4'h0)
	endtask
	task automatic t_shape();
		shaping = 5'h1f;
		pulse(3'b100);
		pulse(3'b010);
		`CHK(pins, 4'h5)
		`CHK(short_n, 1'b1)
		pulse(3'b001);
	endtask
	// dropping enable parks outputs; same-cycle event combinations
	task automatic t_park();
		pulse(3'b100);
		pulse(3'b010);
		`CHK(pins, 4'ha)
		enable = 0;
		@(posedge clk) #1;
		`CHK(phase, 4'h0)
		`CHK(odd_period, 1'b1)
		enable = 1;
		@(posedge clk) #1;
		pulse(3'b110);
		`CHK(pins, 4'h5)
		pulse(3'b011);
		`CHK(pins, 4'h0)
		pulse(3'b110);
		`CHK(pins, 4'ha)
		pulse(3'b100);
		`CHK(pins, 4'h0)
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 arst_n = 1;
		enable = 1;
		@(posedge clk) #1;
		@(posedge clk) #1;
		t_odd();
		t_even();
		t_shape();
		t_park();
		print_verdict();
	end
endmodule
`default_nettype wire
